// ===== rtl/serial_port_control_unit.v
// Behaviour
// - Any reset clears the whole control register to zero.
// - Mode 0: receive-done sets at end of the eighth data bit.
// - Mode 1: receive-done sets after stop bit sample, gated by stop-check bit.
// - Modes 2 and 3: receive-done sets after sampling the ninth bit.
// - Receive-done stays set until software clears it.
// - Transmit-done sets after last data bit, held until software clears.
// - Modes 2 and 3: ninth received bit stored in its field.
// - Mode 1 with stop-check off: ninth-bit field holds the stop bit.
// - Modes 2 and 3: transmit-ninth-bit field sent as ninth bit.
// - Receiver enable off disables reception; on enables modes 1 to 3.
// - Mode 0: setting receiver enable starts one synchronous byte reception.
// - Mode 1 with stop-check on: frame with bad stop bit is discarded.
// - Modes 2/3 multiprocessor: ninth bit zero gives no receive-done, no interrupt.
// - Mode 0 shift clock is system clock over 12, or over 4.
// - Mode bits high,low: 00 mode 0, 10 mode 1, 01 mode 2, 11 mode 3.
// - With frame detect on, low mode bit becomes a sticky framing-error flag.
// - Separate transmit and receive buffers share one data location.
`include "serial_port_defs.vh"

module serial_port_control_unit (
	// Clock and reset
	input wire sys_clk,
	input wire rstn,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Serial line
	input wire baudTick,
	input wire rxdIn,
	output reg rxdOut_ff,
	output reg rxdOe_ff,
	output reg txd_ff,
	// Interrupts
	output reg serialIrq_ff,
	output wire irq
);
	localparam TX_IDLE = 5'b00001;
	localparam TX_START = 5'b00010;
	localparam TX_DATA = 5'b00100;
	localparam TX_NINTH = 5'b01000;
	localparam TX_STOP = 5'b10000;
	localparam RX_IDLE = 5'b00001;
	localparam RX_START = 5'b00010;
	localparam RX_DATA = 5'b00100;
	localparam RX_NINTH = 5'b01000;
	localparam RX_STOP = 5'b10000;

	// Control register fields
	reg rxDone_ff, txDone_ff, rxNinth_ff, txNinth_ff, rxEnable_ff, mpStopCheck_ff;
	reg modeHigh_ff, modeLow_ff, frameErr_ff;
	// Config
	reg frameDetect_ff, baudDouble_ff;
	// Buffers
	reg [7:0] txBuf_ff, rxBuf_ff, rxShift_ff;
	reg [4:0] txState_ff, rxState_ff;
	reg [3:0] txCount_ff, rxCount_ff;
	reg txLine_ff, shiftClk_ff, rxPrev_ff, txRestart_ff, rxRestart_ff;
	reg rxDoneSet, txDoneSet, frameErrSet;
	wire [`EVT_COUNT-1:0] evtStatus, evtMask;

	// Bus decode; one wait state gives the read mux a full cycle
	wire apbAccess = psel & penable;
	wire apbDone = apbAccess & pready;
	wire apbWr = apbDone & pwrite;
	wire ctrlWr = apbWr & (paddr == `OFS_CONTROL);
	wire dataWr = apbWr & (paddr == `OFS_DATA);
	wire cfgWr = apbWr & (paddr == `OFS_CONFIG);
	wire evtClrWr = apbWr & (paddr == `OFS_EVENT_STATUS);
	wire evtMaskWr = apbWr & (paddr == `OFS_EVENT_MASK);
	wire addrHit = (paddr == `OFS_CONTROL) | (paddr == `OFS_DATA) | (paddr == `OFS_CONFIG) |
		(paddr == `OFS_EVENT_STATUS) | (paddr == `OFS_EVENT_MASK);

	// Mode decode
	wire isMode0 = ~modeHigh_ff & ~modeLow_ff;
	wire isMode1 = modeHigh_ff & ~modeLow_ff;
	wire isMode2 = ~modeHigh_ff & modeLow_ff;
	wire nineBit = modeLow_ff;
	wire baudMode = ~isMode0 & ~isMode2;

	reg [`PERIOD_WIDTH-1:0] bitPeriod;
	always @* begin
		if (isMode0) begin
			bitPeriod = mpStopCheck_ff ? `M0_FAST_PERIOD : `M0_SLOW_PERIOD;
		end else if (isMode2) begin
			bitPeriod = baudDouble_ff ? `M2_FAST_PERIOD : `M2_SLOW_PERIOD;
		end else begin
			bitPeriod = baudDouble_ff ? `M13_FAST_PERIOD : `M13_SLOW_PERIOD;
		end
	end
	wire stepEn = baudMode ? baudTick : 1'b1;

	wire txMid, txBit, txHalf, rxMid, rxBit, rxHalf;
	bit_timer #(.W(`PERIOD_WIDTH)) txTimer (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.restart(txRestart_ff),
		.stepEn(stepEn),
		.period(bitPeriod),
		.midTick(txMid),
		.bitTick(txBit),
		.secondHalf(txHalf)
	);
	bit_timer #(.W(`PERIOD_WIDTH)) rxTimer (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.restart(rxRestart_ff),
		.stepEn(stepEn),
		.period(bitPeriod),
		.midTick(rxMid),
		.bitTick(rxBit),
		.secondHalf(rxHalf)
	);

	event_flags #(.N(`EVT_COUNT)) events (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.setEvt({frameErrSet, txDoneSet, rxDoneSet}),
		.clrWr(evtClrWr),
		.maskWr(evtMaskWr),
		.wrData(pwdata[`EVT_COUNT-1:0]),
		.status_ff(evtStatus),
		.mask_ff(evtMask),
		.irq_ff(irq)
	);

	wire txIdle = (txState_ff == TX_IDLE);
	wire rxIdle = (rxState_ff == RX_IDLE);
	wire renRise = ctrlWr & pwdata[`CTL_RX_ENABLE] & ~rxEnable_ff;
	wire txStart = dataWr & txIdle & rxIdle;
	wire m0Rx = isMode0 & ~rxIdle;
	wire m0Tx = isMode0 & ~txIdle;

	// APB slave
	always @(posedge sys_clk) begin
		if (!rstn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= apbAccess & ~pready;
			pslverr <= apbAccess & ~pready & ~addrHit;
			if (apbAccess & ~pready & ~pwrite) begin
				case (paddr)
					`OFS_CONTROL: prdata <= {24'h00_0000,
						frameDetect_ff ? frameErr_ff : modeLow_ff, modeHigh_ff,
						mpStopCheck_ff, rxEnable_ff, txNinth_ff, rxNinth_ff,
						txDone_ff, rxDone_ff};
					`OFS_DATA: prdata <= {24'h00_0000, rxBuf_ff};
					`OFS_CONFIG: prdata <= {30'h0000_0000, baudDouble_ff, frameDetect_ff};
					`OFS_EVENT_STATUS: prdata <= {29'h0000_0000, evtStatus};
					`OFS_EVENT_MASK: prdata <= {29'h0000_0000, evtMask};
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Control register; hardware set wins over a software clear in the same cycle
	always @(posedge sys_clk) begin
		if (!rstn) begin
			{modeLow_ff, modeHigh_ff, mpStopCheck_ff, rxEnable_ff} <= 4'h0;
			{txNinth_ff, txDone_ff, rxDone_ff, frameErr_ff} <= 4'h0;
			frameDetect_ff <= 1'b0;
			baudDouble_ff <= 1'b0;
		end else begin
			rxDone_ff <= rxDoneSet | (ctrlWr ? pwdata[`CTL_RX_DONE] : rxDone_ff);
			txDone_ff <= txDoneSet | (ctrlWr ? pwdata[`CTL_TX_DONE] : txDone_ff);
			frameErr_ff <= frameErrSet |
				((ctrlWr & frameDetect_ff) ? pwdata[`CTL_MODE_LOW] : frameErr_ff);
			if (ctrlWr) begin
				txNinth_ff <= pwdata[`CTL_TX_NINTH];
				rxEnable_ff <= pwdata[`CTL_RX_ENABLE];
				mpStopCheck_ff <= pwdata[`CTL_MP_STOPCHECK];
				modeHigh_ff <= pwdata[`CTL_MODE_HIGH];
				if (!frameDetect_ff) begin
					modeLow_ff <= pwdata[`CTL_MODE_LOW];
				end
			end
			if (cfgWr) begin
				frameDetect_ff <= pwdata[`CFG_FRAME_DETECT];
				baudDouble_ff <= pwdata[`CFG_BAUD_DOUBLE];
			end
		end
	end

	// Transmitter
	always @(posedge sys_clk) begin
		txDoneSet <= 1'b0;
		txRestart_ff <= 1'b0;
		if (!rstn) begin
			txState_ff <= TX_IDLE;
			txBuf_ff <= `DATA_RESET;
			txCount_ff <= 4'h0;
			txLine_ff <= 1'b1;
			rxdOut_ff <= 1'b1;
			rxdOe_ff <= 1'b0;
			txDoneSet <= 1'b0;
		end else begin
			case (txState_ff)
				TX_IDLE: begin
					if (txStart) begin
						txBuf_ff <= pwdata[7:0];
						txCount_ff <= 4'h0;
						txRestart_ff <= 1'b1;
						if (isMode0) begin
							rxdOut_ff <= pwdata[0];
							rxdOe_ff <= 1'b1;
							txState_ff <= TX_DATA;
						end else begin
							txLine_ff <= 1'b0;
							txState_ff <= TX_START;
						end
					end
				end
				TX_START: begin
					if (txBit) begin
						txLine_ff <= txBuf_ff[0];
						txState_ff <= TX_DATA;
					end
				end
				TX_DATA: begin
					if (txBit) begin
						txCount_ff <= txCount_ff + 4'h1;
						txBuf_ff <= {1'b1, txBuf_ff[7:1]};
						if (txCount_ff == 4'h7) begin
							if (isMode0) begin
								rxdOe_ff <= 1'b0;
								rxdOut_ff <= 1'b1;
								txDoneSet <= 1'b1;
								txState_ff <= TX_IDLE;
							end else if (nineBit) begin
								txLine_ff <= txNinth_ff;
								txState_ff <= TX_NINTH;
							end else begin
								txLine_ff <= 1'b1;
								txDoneSet <= 1'b1;
								txState_ff <= TX_STOP;
							end
						end else if (isMode0) begin
							rxdOut_ff <= txBuf_ff[1];
						end else begin
							txLine_ff <= txBuf_ff[1];
						end
					end
				end
				TX_NINTH: begin
					if (txBit) begin
						txLine_ff <= 1'b1;
						txDoneSet <= 1'b1;
						txState_ff <= TX_STOP;
					end
				end
				TX_STOP: begin
					if (txBit) begin
						txState_ff <= TX_IDLE;
					end
				end
				default: txState_ff <= TX_IDLE;
			endcase
		end
	end

	// Receiver
	always @(posedge sys_clk) begin
		rxDoneSet <= 1'b0;
		frameErrSet <= 1'b0;
		rxRestart_ff <= 1'b0;
		if (!rstn) begin
			rxState_ff <= RX_IDLE;
			rxShift_ff <= 8'h00;
			rxBuf_ff <= `DATA_RESET;
			rxCount_ff <= 4'h0;
			rxNinth_ff <= 1'b0;
			rxPrev_ff <= 1'b1;
		end else begin
			rxPrev_ff <= rxdIn;
			case (rxState_ff)
				RX_IDLE: begin
					rxCount_ff <= 4'h0;
					if (isMode0 & renRise & txIdle) begin
						rxRestart_ff <= 1'b1;
						rxState_ff <= RX_DATA;
					end else if (~isMode0 & rxEnable_ff & rxPrev_ff & ~rxdIn) begin
						rxRestart_ff <= 1'b1;
						rxState_ff <= RX_START;
					end
				end
				RX_START: begin
					// A start bit that is high again at mid bit was a glitch
					if (rxMid & rxdIn) begin
						rxState_ff <= RX_IDLE;
					end else if (rxBit) begin
						rxState_ff <= RX_DATA;
					end
				end
				RX_DATA: begin
					// Mode 0 samples at bit end: the pin clock lags the timer by two registers
					if (isMode0 ? rxBit : rxMid) begin
						rxShift_ff <= {rxdIn, rxShift_ff[7:1]};
						rxCount_ff <= rxCount_ff + 4'h1;
					end
					if (rxBit & (rxCount_ff == (isMode0 ? 4'h7 : 4'h8))) begin
						if (isMode0) begin
							rxBuf_ff <= {rxdIn, rxShift_ff[7:1]};
							rxDoneSet <= 1'b1;
							rxState_ff <= RX_IDLE;
						end else if (nineBit) begin
							rxState_ff <= RX_NINTH;
						end else begin
							rxState_ff <= RX_STOP;
						end
					end
				end
				RX_NINTH: begin
					if (rxMid & ~(mpStopCheck_ff & ~rxdIn)) begin
						rxBuf_ff <= rxShift_ff;
						rxNinth_ff <= rxdIn;
						rxDoneSet <= 1'b1;
					end
					if (rxBit) begin
						rxState_ff <= RX_STOP;
					end
				end
				RX_STOP: begin
					if (rxMid) begin
						frameErrSet <= frameDetect_ff & ~rxdIn;
						if (isMode1 & ~(mpStopCheck_ff & ~rxdIn)) begin
							rxBuf_ff <= rxShift_ff;
							rxNinth_ff <= rxdIn;
							rxDoneSet <= 1'b1;
						end
						rxState_ff <= RX_IDLE;
					end
				end
				default: rxState_ff <= RX_IDLE;
			endcase
		end
	end

	// Line outputs; mode 0 shift clock idles high and is low in each bit's first half
	always @(posedge sys_clk) begin
		if (!rstn) begin
			shiftClk_ff <= 1'b1;
			txd_ff <= 1'b1;
			serialIrq_ff <= 1'b0;
		end else begin
			shiftClk_ff <= ~((m0Tx & ~txHalf) | (m0Rx & ~rxHalf));
			txd_ff <= isMode0 ? shiftClk_ff : txLine_ff;
			serialIrq_ff <= rxDone_ff | txDone_ff;
		end
	end
endmodule

// ===== rtl/serial_port_defs.vh
`ifndef SERIAL_PORT_DEFS_VH
`define SERIAL_PORT_DEFS_VH

// Register byte offsets
`define OFS_CONTROL 8'h00
`define OFS_DATA 8'h04
`define OFS_CONFIG 8'h08
`define OFS_EVENT_STATUS 8'h0c
`define OFS_EVENT_MASK 8'h10

// Control register field positions
`define CTL_RX_DONE 0
`define CTL_TX_DONE 1
`define CTL_RX_NINTH 2
`define CTL_TX_NINTH 3
`define CTL_RX_ENABLE 4
`define CTL_MP_STOPCHECK 5
`define CTL_MODE_HIGH 6
`define CTL_MODE_LOW 7

// Config register field positions
`define CFG_FRAME_DETECT 0
`define CFG_BAUD_DOUBLE 1

// Event status and mask bits
`define EVT_RX_DONE 0
`define EVT_TX_DONE 1
`define EVT_FRAME_ERR 2
`define EVT_COUNT 3

// Reset values
`define CONTROL_RESET 8'h00
`define DATA_RESET 8'h00

// Bit periods, in system clocks for modes 0 and 2, in baud ticks for modes 1 and 3
`define M0_SLOW_PERIOD 7'h0c
`define M0_FAST_PERIOD 7'h04
`define M2_SLOW_PERIOD 7'h40
`define M2_FAST_PERIOD 7'h20
`define M13_SLOW_PERIOD 7'h40
`define M13_FAST_PERIOD 7'h10
`define PERIOD_WIDTH 7

`endif

// ===== rtl/bit_timer.v
module bit_timer #(
	parameter W = 7
) (
	// Clock and reset
	input wire sys_clk,
	input wire rstn,
	// Control
	input wire restart,
	input wire stepEn,
	input wire [W-1:0] period,
	// Timing pulses
	output wire midTick,
	output wire bitTick,
	output wire secondHalf
);
	reg [W-1:0] count_ff;
	wire [W-1:0] lastCount = period - {{(W-1){1'b0}}, 1'b1};
	wire [W-1:0] halfCount = {1'b0, period[W-1:1]};

	assign bitTick = stepEn & ~restart & (count_ff == lastCount);
	assign midTick = stepEn & ~restart & (count_ff == halfCount - {{(W-1){1'b0}}, 1'b1});
	assign secondHalf = (count_ff >= halfCount);

	always @(posedge sys_clk) begin
		if (!rstn || restart) begin
			count_ff <= {W{1'b0}};
		end else if (bitTick) begin
			count_ff <= {W{1'b0}};
		end else if (stepEn) begin
			count_ff <= count_ff + {{(W-1){1'b0}}, 1'b1};
		end
	end
endmodule

// ===== rtl/event_flags.v
module event_flags #(
	parameter N = 3
) (
	// Clock and reset
	input wire sys_clk,
	input wire rstn,
	// Hardware events
	input wire [N-1:0] setEvt,
	// Software access
	input wire clrWr,
	input wire maskWr,
	input wire [N-1:0] wrData,
	// State
	output reg [N-1:0] status_ff,
	output reg [N-1:0] mask_ff,
	output reg irq_ff
);
	// A new event in the clearing cycle survives
	wire [N-1:0] nxt_status = setEvt | (status_ff & ~(clrWr ? wrData : {N{1'b0}}));

	always @(posedge sys_clk) begin
		if (!rstn) begin
			status_ff <= {N{1'b0}};
			mask_ff <= {N{1'b0}};
			irq_ff <= 1'b0;
		end else begin
			status_ff <= nxt_status;
			if (maskWr) begin
				mask_ff <= wrData;
			end
			irq_ff <= |(status_ff & mask_ff);
		end
	end
endmodule

// ===== sim/serial_port_chk.sv
`include "serial_port_defs.vh"

module serial_port_chk (
	// Clock and reset
	input wire sys_clk,
	input wire rstn,
	// APB
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	// Line and interrupt
	input wire txd_ff,
	input wire rxdOe_ff,
	input wire serialIrq_ff
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_read;
		pready && !pwrite;
	endsequence
	chk_reset_clear: assert property (disable iff (1'b0) !rstn |=> txd_ff && !serialIrq_ff)
		else $error("outputs not cleared by reset");
	chk_ready_wait: assert property (s_setup ##1 (psel && penable && !pready) |=> pready)
		else $error("pready not in second access cycle");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error response malformed");
	chk_upper_zero: assert property (s_read |-> prdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	chk_unmapped_err: assert property (pready && paddr > `OFS_EVENT_MASK |-> pslverr)
		else $error("unmapped access not refused");
	chk_irq_follows: assert property (s_read and (paddr == `OFS_CONTROL && prdata[1:0] != 2'b00)
		|-> ##[0:1] serialIrq_ff)
		else $error("serial request low with done flag set");
	chk_shift_low: assert property ($fell(txd_ff) |=> !txd_ff)
		else $error("line low phase too short");
endmodule

bind serial_port_control_unit serial_port_chk u_serial_port_chk (.sys_clk(sys_clk),
	.rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .txd_ff(txd_ff),
	.rxdOe_ff(rxdOe_ff), .serialIrq_ff(serialIrq_ff));

// ===== sim/line_partner.sv
module line_partner (
	// Clock and line
	input wire sys_clk,
	input wire txd,
	output logic rxd
);
	timeunit 1ns;
	timeprecision 1ns;
	initial rxd = 1'b1;
	// Start bit, n bits LSB first, then stop level; idle high after
	task automatic send(input [8:0] d, input int n, input int per, input stp);
		int i;
		@(posedge sys_clk);
		rxd <= 1'b0;
		repeat (per) @(posedge sys_clk);
		for (i = 0; i < n; i++) begin
			rxd <= d[i];
			repeat (per) @(posedge sys_clk);
		end
		rxd <= stp;
		repeat (per) @(posedge sys_clk);
		rxd <= 1'b1;
	endtask
	// Samples mid bit, so small skew of the start edge is tolerated
	task automatic grab(output [8:0] d, input int n, input int per);
		int i;
		d = 9'h000;
		while (txd !== 1'b0) @(posedge sys_clk);
		repeat (per + per / 2) @(posedge sys_clk);
		for (i = 0; i < n; i++) begin
			d[i] = txd;
			repeat (per) @(posedge sys_clk);
		end
	endtask
	// Synchronous mode: new bit on each falling shift clock
	task automatic sync0(input [7:0] d, output int per);
		int i;
		int t;
		per = 0;
		t = 0;
		for (i = 0; i < 8; i++) begin
			while (txd !== 1'b0) begin
				@(posedge sys_clk);
				t++;
			end
			rxd <= d[i];
			if (i == 1) per = t;
			t = 0;
			while (txd !== 1'b1) begin
				@(posedge sys_clk);
				t++;
			end
		end
		rxd <= 1'b1;
	endtask
endmodule

// ===== sim/serial_port_control_unit_tb.sv
`include "serial_port_defs.vh"

module serial_port_control_unit_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic baudTick = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	wire [31:0] prdata;
	wire pready, pslverr, rxdOut_ff, rxdOe_ff, txd_ff, serialIrq_ff, irq, lineRxd;
	wire rxdIn = rxdOe_ff ? rxdOut_ff : lineRxd;
	int n_fail = 0;
	int n_compared = 0;
	int cyc = 0;
	int i;
	int per;
	logic [32:0] expQ[$];
	logic [8:0] got;
	logic [7:0] d;
	logic [7:0] rxv = 8'h00;
	logic m1;
	logic [7:0] tc [8] = '{8'h90, 8'h90, 8'hb0, 8'hb0, 8'h80, 8'h50, 8'h70, 8'h50};
	// A refused or skipped frame leaves the ninth-bit field as the last stored frame set it
	logic [7:0] te [8] = '{8'h91, 8'h95, 8'hb4, 8'hb5, 8'h84, 8'h55, 8'h74, 8'hd1};
	logic tb9 [8] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

	serial_port_control_unit u_serial_port_control_unit (.sys_clk(sys_clk), .rstn(rstn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .baudTick(baudTick),
		.rxdIn(rxdIn), .rxdOut_ff(rxdOut_ff), .rxdOe_ff(rxdOe_ff), .txd_ff(txd_ff),
		.serialIrq_ff(serialIrq_ff), .irq(irq));
	line_partner u_line_partner (.sys_clk(sys_clk), .txd(txd_ff), .rxd(lineRxd));

	initial forever #20 sys_clk = ~sys_clk;
	// Baud pulses every second clock, so one bit of mode 1 is 128 clocks
	always @(posedge sys_clk) baudTick <= ~baudTick;

	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		if (n_fail == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// Reads note the expected response; an idle edge first keeps drives apart
	task automatic apb(input w, input [7:0] a, input [31:0] v, input e);
		@(posedge sys_clk);
		if (!w) expQ.push_back({e, v});
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= w ? v : 32'h0;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) @(posedge sys_clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	always @(posedge sys_clk) begin
		if (psel && penable && !pwrite && pready === 1'b1)
			check({pslverr, prdata}, expQ.pop_front());
	end
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_fail++;
			test_done();
		end
	end

	initial begin
		void'($urandom(32'h5089));
		repeat (8) @(posedge sys_clk);
		rstn <= 1'b1;
		apb(0, `OFS_CONTROL, 32'h0, 0);
		apb(0, `OFS_DATA, 32'h0, 0);
		apb(0, 8'h14, 32'h0, 1);
		apb(1, `OFS_EVENT_MASK, 32'h2, 0);
		apb(1, `OFS_CONTROL, 32'h88, 0);
		d = $urandom;
		apb(1, `OFS_DATA, {24'h0, d}, 0);
		u_line_partner.grab(got, 9, 64);
		check({24'h0, got}, {24'h0, 1'b1, d});
		apb(0, `OFS_CONTROL, 32'h8a, 0);
		apb(0, `OFS_EVENT_STATUS, 32'h2, 0);
		check({32'h0, irq}, 33'h1);
		apb(1, `OFS_EVENT_MASK, 32'h0, 0);
		repeat (2) @(posedge sys_clk);
		check({32'h0, irq}, 33'h0);
		apb(1, `OFS_EVENT_MASK, 32'h2, 0);
		repeat (2) @(posedge sys_clk);
		check({32'h0, irq}, 33'h1);
		apb(1, `OFS_EVENT_STATUS, 32'h7, 0);
		repeat (2) @(posedge sys_clk);
		check({32'h0, irq}, 33'h0);
		for (i = 0; i < 8; i++) begin
			m1 = tc[i][6];
			apb(1, `OFS_CONFIG, {31'h0, i == 7}, 0);
			apb(1, `OFS_CONTROL, {24'h0, tc[i]}, 0);
			d = $urandom;
			u_line_partner.send({tb9[i], d}, m1 ? 8 : 9, m1 ? 128 : 64, m1 ? tb9[i] : 1'b1);
			if (te[i][0]) rxv = d;
			apb(0, `OFS_CONTROL, {24'h0, te[i]}, 0);
			apb(0, `OFS_DATA, {24'h0, rxv}, 0);
			check({32'h0, serialIrq_ff}, {32'h0, te[i][0]});
		end
		apb(1, `OFS_CONFIG, 32'h0, 0);
		for (i = 0; i < 2; i++) begin
			apb(1, `OFS_CONTROL, {26'h0, i[0], 5'h00}, 0);
			apb(1, `OFS_CONTROL, {26'h0, i[0], 5'h10}, 0);
			d = $urandom;
			u_line_partner.sync0(d, per);
			check(per, i ? 4 : 12);
			repeat (12) @(posedge sys_clk);
			apb(0, `OFS_CONTROL, {26'h0, i[0], 5'h11}, 0);
			apb(0, `OFS_DATA, {24'h0, d}, 0);
		end
		test_done();
	end
endmodule
